// ===== xbar_pkg.sv
// Shared constants for the port crossbar decoder
package xbar_pkg;
  // Pin counts: all pins, pins the router may claim, routed signal slots
  localparam int NP = 21;
  localparam int NA = 20;
  localparam int NS = 17;
  // Fixed serial port pins
  localparam int UART_TX_PIN = 4;
  localparam int UART_RX_PIN = 5;
  localparam logic [NA-1:0] UART_MASK = 20'h00030;
  localparam logic [NP-1:0] UART_TX_MASK = 21'h000010;
  // resource_enable_reg_a field positions
  localparam int RA_UART = 0;
  localparam int RA_SPI = 1;
  localparam int RA_SMB0 = 2;
  localparam int RA_SYSCLK = 3;
  localparam int RA_CP0 = 4;
  localparam int RA_CP0A = 5;
  localparam int RA_SMB1 = 6;
  // resource_enable_reg_b field positions
  localparam int RB_PCA_LO = 0;
  localparam int RB_ECI = 3;
  localparam int RB_T0 = 4;
  localparam int RB_T1 = 5;
  localparam int RB_ROUTER_EN = 6;
  localparam int RB_WPU_DIS = 7;
  // PCA channel routing codes
  localparam logic [1:0] PCA_NONE = 2'h0;
  localparam logic [1:0] PCA_ONE = 2'h1;
  localparam logic [1:0] PCA_THREE = 2'h3;
  // ext_interrupt_pin_select field positions
  localparam int EI0_LO = 0;
  localparam int EI1_LO = 4;
  // Routed signal slots in priority order
  localparam int S_SCK = 0;
  localparam int S_MISO = 1;
  localparam int S_MOSI = 2;
  localparam int S_NSS = 3;
  localparam int S_SDA0 = 4;
  localparam int S_SCL0 = 5;
  localparam int S_SDA1 = 6;
  localparam int S_SCL1 = 7;
  localparam int S_CP0 = 8;
  localparam int S_CP0A = 9;
  localparam int S_SYSCLK = 10;
  localparam int S_PCA_CHANNEL0_IO = 11;
  localparam int S_CEX1 = 12;
  localparam int S_CEX2 = 13;
  localparam int S_ECI = 14;
  localparam int S_T0 = 15;
  localparam int S_T1 = 16;
  // Reset values
  localparam logic [NP-1:0] IN_MODE_RST = 21'h1FFFFF;
  localparam logic [NP-1:0] OUT_MODE_RST = 21'h000000;
  localparam logic [NP-1:0] LATCH_RST = 21'h1FFFFF;
  localparam logic [NA-1:0] SKIP_RST = 20'h00000;
  localparam logic [7:0] REG_RST = 8'h00;
endpackage

// ===== pick_if.sv
// Link between one allocation stage and the crossbar chain
`timescale 1ns/1ps
interface pick_if;
  import xbar_pkg::*;
  logic [NA-1:0] mask_in;
  logic req;
  logic [NA-1:0] grant;
  logic [NA-1:0] mask_out;
  modport picker (input mask_in, input req, output grant, output mask_out);
  modport chain (output mask_in, output req, input grant, input mask_out);
endinterface

// ===== pin_picker.sv
// One allocation stage: grants the lowest pin not yet taken
`timescale 1ns/1ps
module pin_picker
  import xbar_pkg::*;
(
  pick_if.picker port
);
  logic [NA-1:0] free;
  logic [NA-1:0] lowest;

  // Lowest free pin; with none free the request stays unrouted
  assign free = ~port.mask_in;
  assign lowest = free & (~free + {{(NA-1){1'b0}}, 1'b1}); // see R1, see R3, see R24
  assign port.grant = port.req ? lowest : '0;
  assign port.mask_out = port.mask_in | port.grant;
endmodule

// ===== port_crossbar_decoder.sv
// Priority crossbar routing peripherals onto port pins, with pad mode control
// Contract
// R1 - Enabled resources served in priority order, each taking lowest free unskipped pin.
// R2 - Enabled UART always sits on P0.4 transmit and P0.5 receive.
// R3 - Skipped pins are passed over exactly like taken pins.
// R4 - SMBus and UART each claim both their pins together; SMBus data can take the last free pin without its clock.
// R5 - SMBus data/clock placement on its two pins follows the swap setting.
// R6 - SPI slave select routed only in 4-wire mode.
// R7 - Leftover pins act as plain general-purpose pins.
// R8 - With router disabled all pins are plain inputs, enables ignored.
// R9 - Output drivers off while router disabled.
// R10 - Input mode bit 1 digital, 0 analog; reset gives digital.
// R11 - Analog pins lose pull-up, output driver and input receiver.
// R12 - Output mode bit picks push-pull or open-drain; SMBus always open-drain.
// R13 - Weak pull-up on open-drain pins unless disabled; off while driving low.
// R14 - Event triggers work on digital pins, skipped or routed, never analog.
// R15 - External interrupts select P0 pins; port match covers P0 and P1.
// R16 - Software configures modes, skips, enables, then the router enable.
// R17 - Software skips pins used by analog, bypassing or GPIO functions.
// R18 - Software skips reference, oscillator and conversion-start pins when used.
// R19 - Allocation spans P0.0 to P2.3; GPIO spans P0.0 to P2.4.
// R20 - Analog pins read back zero.
// R21 - Digital pins read back the pad level.
// R22 - PCA field routes none, channel 0, channels 0-1, or channels 0-2.
// R23 - Allocation recomputed from current settings, no stored history.
// R24 - A resource finding no free pin stays unrouted, others undisturbed.
`timescale 1ns/1ps
module port_crossbar_decoder
  import xbar_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [NP-1:0] pin_input_mode_bits_in,
  input wire logic [NP-1:0] pin_output_mode_bits_in,
  input wire logic [NA-1:0] pin_skip_bits_in,
  input wire logic [NP-1:0] port_latch_in,
  input wire logic [7:0] resource_enable_reg_a_in,
  input wire logic [7:0] resource_enable_reg_b_in,
  input wire logic [1:0] serial_pin_order_swap_in,
  input wire logic slave_select_mode_in,
  input wire logic [7:0] ext_interrupt_pin_select_in,
  input wire logic [7:0] match_value_port0_in,
  input wire logic [7:0] match_mask_port0_in,
  input wire logic [7:0] match_value_port1_in,
  input wire logic [7:0] match_mask_port1_in,
  input wire logic uart_transmit_line_in,
  input wire logic [NS-1:0] periph_out_in,
  input wire logic [NS-1:0] periph_oe_in,
  input wire logic [NP-1:0] pad_in,
  output logic [NP-1:0] pad_out_out,
  output logic [NP-1:0] pad_oe_out,
  output logic [NP-1:0] pad_pullup_out,
  output logic [NP-1:0] port_read_out,
  output logic [NA-1:0] pin_routed_out,
  output logic [NS-1:0] periph_in_out,
  output logic uart_receive_line_out,
  output logic [1:0] ext_int_out,
  output logic port_mismatch_out
);
  logic [NP-1:0] cfg_in_mode;
  logic [NP-1:0] cfg_out_mode;
  logic [NA-1:0] cfg_skip;
  logic [NP-1:0] cfg_latch;
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic [1:0] cfg_swap;
  logic cfg_nss4;
  logic [7:0] cfg_eisel;
  logic [31:0] cfg_match;
  logic [NP-1:0] sync1;
  logic [NP-1:0] sync2;
  logic [NP-1:0] sync3;
  logic [NP-1:0] pad_lvl;

  // Settings captured every cycle; mode bits come up digital
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_in_mode <= IN_MODE_RST; // see R10
      cfg_out_mode <= OUT_MODE_RST;
      cfg_skip <= SKIP_RST;
      cfg_latch <= LATCH_RST;
      cfg_a <= REG_RST;
      cfg_b <= REG_RST;
      cfg_swap <= 2'h0;
      cfg_nss4 <= 1'b0;
      cfg_eisel <= 8'h00;
      cfg_match <= 32'h00000000;
    end else begin
      cfg_in_mode <= pin_input_mode_bits_in;
      cfg_out_mode <= pin_output_mode_bits_in;
      cfg_skip <= pin_skip_bits_in;
      cfg_latch <= port_latch_in;
      cfg_a <= resource_enable_reg_a_in;
      cfg_b <= resource_enable_reg_b_in;
      cfg_swap <= serial_pin_order_swap_in;
      cfg_nss4 <= slave_select_mode_in;
      cfg_eisel <= ext_interrupt_pin_select_in;
      cfg_match <= {match_mask_port1_in, match_value_port1_in,
                    match_mask_port0_in, match_value_port0_in};
    end
  end

  // Pad synchroniser; level follows once stages two and three agree
  logic [NP-1:0] next_lvl;
  assign next_lvl = (sync2 & sync3) | (pad_lvl & (sync2 ^ sync3));
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pad_lvl <= '0;
    end else begin
      sync1 <= pad_in;
      sync2 <= sync1;
      sync3 <= sync2;
      pad_lvl <= next_lvl;
    end
  end

  // Resource requests, all gated by the router enable
  logic xbar_on;
  logic wpu_dis;
  logic uart_on;
  logic spi_on;
  logic [1:0] pca_sel;
  logic [NS-1:0] req;
  assign xbar_on = cfg_b[RB_ROUTER_EN];
  assign wpu_dis = cfg_b[RB_WPU_DIS];
  assign uart_on = xbar_on & cfg_a[RA_UART]; // see R8
  assign spi_on = xbar_on & cfg_a[RA_SPI];
  assign pca_sel = cfg_b[RB_PCA_LO +: 2];
  assign req[S_SCK] = spi_on;
  assign req[S_MISO] = spi_on;
  assign req[S_MOSI] = spi_on;
  assign req[S_NSS] = spi_on & cfg_nss4; // see R6
  assign req[S_SDA0] = xbar_on & cfg_a[RA_SMB0]; // see R4
  assign req[S_SCL0] = xbar_on & cfg_a[RA_SMB0];
  assign req[S_SDA1] = xbar_on & cfg_a[RA_SMB1];
  assign req[S_SCL1] = xbar_on & cfg_a[RA_SMB1];
  assign req[S_CP0] = xbar_on & cfg_a[RA_CP0];
  assign req[S_CP0A] = xbar_on & cfg_a[RA_CP0A];
  assign req[S_SYSCLK] = xbar_on & cfg_a[RA_SYSCLK];
  assign req[S_PCA_CHANNEL0_IO] = xbar_on & (pca_sel != PCA_NONE); // see R22
  assign req[S_CEX1] = xbar_on & (pca_sel > PCA_ONE);
  assign req[S_CEX2] = xbar_on & (pca_sel == PCA_THREE);
  assign req[S_ECI] = xbar_on & cfg_b[RB_ECI];
  assign req[S_T0] = xbar_on & cfg_b[RB_T0];
  assign req[S_T1] = xbar_on & cfg_b[RB_T1];

  // Starting mask: skipped pins plus the fixed serial pair
  logic [NA-1:0] base_mask;
  assign base_mask = cfg_skip | (uart_on ? UART_MASK : '0); // see R2, see R3, see R19

  // Allocation chain, purely combinational from current settings
  pick_if link [NS] ();
  logic [NA-1:0] gmat [NS];
  logic [NA-1:0] emat [NS];
  genvar s;
  genvar p;
  genvar q;
  generate
    for (s = 0; s < NS; s++) begin : g_slot
      localparam int PART = (s >= S_SDA0 && s <= S_SCL1) ? (s ^ 1) : s;
      localparam bit IS0 = (s == S_SDA0) || (s == S_SCL0);
      localparam bit IS1 = (s == S_SDA1) || (s == S_SCL1);
      logic swp;
      assign link[s].req = req[s];
      if (s == 0) begin : g_first
        assign link[s].mask_in = base_mask; // see R23
      end else begin : g_next
        assign link[s].mask_in = link[s-1].mask_out; // see R1
      end
      pin_picker u_pick (
        .port(link[s])
      );
      assign gmat[s] = link[s].grant;
      // Data and clock exchange pins under the swap setting
      assign swp = (IS0 & cfg_swap[0]) | (IS1 & cfg_swap[1]);
      assign emat[s] = swp ? gmat[PART] : gmat[s]; // see R5
    end
  endgenerate

  // Per-pin view of the routed resources
  logic [NA-1:0] res_own;
  logic [NA-1:0] res_val;
  logic [NA-1:0] res_drv;
  logic [NA-1:0] smb_mask;
  generate
    for (p = 0; p < NA; p++) begin : g_pin
      logic [NS-1:0] col;
      for (q = 0; q < NS; q++) begin : g_col
        assign col[q] = emat[q][p];
      end
      assign res_own[p] = |col;
      assign res_val[p] = |(col & periph_out_in);
      assign res_drv[p] = |(col & periph_oe_in);
    end
  endgenerate
  assign smb_mask = emat[S_SDA0] | emat[S_SCL0] | emat[S_SDA1] | emat[S_SCL1];

  // Drive request and value per pin; unclaimed pins follow the latch
  logic [NP-1:0] own_np;
  logic [NP-1:0] gpio;
  logic [NP-1:0] want;
  logic [NP-1:0] val;
  logic [NP-1:0] tx_mask;
  logic [NP-1:0] pp;
  logic [NP-1:0] act;
  logic [NP-1:0] next_oe;
  logic [NP-1:0] next_out;
  logic [NP-1:0] next_pull;
  logic [NP-1:0] rd_lvl;
  assign own_np = {1'b0, res_own | (uart_on ? UART_MASK : '0)};
  assign gpio = ~own_np; // see R7
  assign tx_mask = uart_on ? UART_TX_MASK : '0; // see R2
  assign want = gpio | {1'b0, res_drv} | tx_mask;
  assign val = (gpio & cfg_latch) | {1'b0, res_val & res_own}
             | (uart_transmit_line_in ? tx_mask : '0);
  assign pp = cfg_out_mode & ~{1'b0, smb_mask}; // see R12
  assign act = cfg_in_mode & {NP{xbar_on}} & want; // see R9, see R11
  assign next_oe = act & (pp | ~val);
  assign next_out = act & pp & val;
  assign next_pull = cfg_in_mode & ~{NP{wpu_dis}} & ~pp & ~(next_oe & ~next_out); // see R13
  assign rd_lvl = pad_lvl & cfg_in_mode; // see R20, see R21

  // Event triggers on digital pins only
  logic [2:0] ei0_sel;
  logic [2:0] ei1_sel;
  logic [1:0] next_ei;
  logic [15:0] mval;
  logic [15:0] mmask;
  logic next_mis;
  logic [NS-1:0] next_pin;
  assign ei0_sel = cfg_eisel[EI0_LO +: 3];
  assign ei1_sel = cfg_eisel[EI1_LO +: 3];
  assign next_ei = {rd_lvl[ei1_sel], rd_lvl[ei0_sel]}; // see R14, see R15
  assign mval = {cfg_match[23:16], cfg_match[7:0]};
  assign mmask = {cfg_match[31:24], cfg_match[15:8]};
  assign next_mis = |((rd_lvl[15:0] ^ mval) & mmask & cfg_in_mode[15:0]); // see R15
  generate
    for (s = 0; s < NS; s++) begin : g_rx
      assign next_pin[s] = |(emat[s] & rd_lvl[NA-1:0]);
    end
  endgenerate

  // Output registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pad_out_out <= '0;
      pad_oe_out <= '0;
      pad_pullup_out <= '0;
      port_read_out <= '0;
      pin_routed_out <= '0;
      periph_in_out <= '0;
      uart_receive_line_out <= 1'b0;
      ext_int_out <= 2'h0;
      port_mismatch_out <= 1'b0;
    end else begin
      pad_out_out <= next_out;
      pad_oe_out <= next_oe;
      pad_pullup_out <= next_pull;
      port_read_out <= rd_lvl;
      pin_routed_out <= own_np[NA-1:0];
      periph_in_out <= next_pin;
      uart_receive_line_out <= rd_lvl[UART_RX_PIN] & uart_on;
      ext_int_out <= next_ei;
      port_mismatch_out <= next_mis;
    end
  end

  // Checks
  a_router_off_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R8
    !$past(xbar_on) |-> (pad_oe_out == '0 && pin_routed_out == '0))
    else $error("pins driven or routed while router disabled");
  a_no_drive_off: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R9
    !xbar_on ##1 !xbar_on |-> pad_out_out == '0)
    else $error("output value present while router disabled");
  a_analog_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R11
    ((pad_oe_out | pad_pullup_out) & ~$past(cfg_in_mode)) == '0)
    else $error("analog pin has driver or pull-up");
  a_analog_reads_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R20
    (port_read_out & ~$past(cfg_in_mode)) == '0)
    else $error("analog pin reads nonzero");
  a_digital_reads_pad: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R21
    $past(cfg_in_mode[0]) |-> port_read_out[0] == $past(pad_lvl[0]))
    else $error("digital pin read differs from pad level");
  a_uart_fixed_pins: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R2
    $past(uart_on) |-> pin_routed_out[UART_TX_PIN] && pin_routed_out[UART_RX_PIN]
      && uart_receive_line_out == $past(pad_lvl[UART_RX_PIN] & cfg_in_mode[UART_RX_PIN]))
    else $error("uart not on its fixed pins");
  a_skip_never_routed: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R3
    (res_own & cfg_skip) == '0)
    else $error("skipped pin was granted");
  a_first_lowest: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R1
    spi_on && base_mask != '1 |-> gmat[S_SCK] == (~base_mask & (base_mask + 20'h00001)))
    else $error("first resource not on lowest free pin");
  a_smb_pair: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R4
    (gmat[S_SCL0] != '0) |-> (gmat[S_SDA0] != '0))
    else $error("smbus clock placed without data");
  a_smb_open_drain: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R12
    ##1 ($past({1'b0, smb_mask}) & pad_out_out) == '0)
    else $error("smbus pin driven high");
  a_pullup_low_off: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R13
    (pad_pullup_out & pad_oe_out & ~pad_out_out) == '0)
    else $error("pull-up on while driving low");
  a_nss_three_wire: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R6
    !cfg_nss4 |-> gmat[S_NSS] == '0)
    else $error("slave select routed in 3-wire mode");
  a_pca_one_channel: assert property (@(posedge clk_in) disable iff (!arst_n_in) // see R22
    pca_sel == PCA_ONE |-> gmat[S_CEX1] == '0 && gmat[S_CEX2] == '0)
    else $error("extra pca channel routed");
  c_uart_routed: cover property (@(posedge clk_in) disable iff (!arst_n_in) uart_on ##1 pad_oe_out[UART_TX_PIN]);
  c_smb_swapped: cover property (@(posedge clk_in) disable iff (!arst_n_in) cfg_swap[0] && req[S_SDA0]);
  c_spi_four_wire: cover property (@(posedge clk_in) disable iff (!arst_n_in) gmat[S_NSS] != '0);
  c_mismatch: cover property (@(posedge clk_in) disable iff (!arst_n_in) $rose(port_mismatch_out));
endmodule

// ===== pad_world.sv
// Board pads, pull resistors and outside drivers around the crossbar
`timescale 1ns/1ps
module pad_world
  import xbar_pkg::*;
(
  input wire logic clk_in,
  input wire logic [NP-1:0] pad_out_in,
  input wire logic [NP-1:0] pad_oe_in,
  input wire logic [NP-1:0] pad_pullup_in,
  input wire logic [NP-1:0] ext_level_in,
  input wire logic [NP-1:0] ext_drive_in,
  output logic [NP-1:0] pad_level_out
);
  logic [NP-1:0] float_pat = 21'h000000;
  // A pad nobody drives or pulls wanders, so it never keeps its last level
  always @(posedge clk_in) begin
    float_pat <= ~float_pat;
  end
  // Chip driver first, then the board, then the weak pull-up
  assign pad_level_out = (pad_oe_in & pad_out_in) | (~pad_oe_in & ext_drive_in & ext_level_in)
    | (~pad_oe_in & ~ext_drive_in & (pad_pullup_in | float_pat));
endmodule

// ===== tb_top.sv
// Self-checking bench for the port crossbar decoder
`timescale 1ns/1ps
module tb_top;
  import xbar_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [NP-1:0] mdin = IN_MODE_RST;
  logic [NP-1:0] mdout = 21'h000000, latch = 21'h000000, ext_lvl = 21'h000000;
  logic [NP-1:0] ext_en = 21'h1FFFFF;
  logic [NA-1:0] skip = 20'h00000;
  logic [7:0] ra = 8'h00, rb = 8'h00, eisel = 8'h00;
  logic [7:0] mv0 = 8'h00, mm0 = 8'h00, mv1 = 8'h00, mm1 = 8'h00;
  logic [1:0] swp = 2'h0;
  logic ssm = 1'b0, utx = 1'b0;
  logic [NS-1:0] pout = 17'h00000, poe = 17'h00000;
  wire [NP-1:0] pad;
  logic [NP-1:0] pad_out, pad_oe, pull, rd, e_oe, e_out, e_pu, e_pad, e_kn, e_rd;
  logic [NA-1:0] routed, e_rt;
  logic [NS-1:0] pin_in, e_pin, k_pin;
  logic urx, mism;
  logic [1:0] eint;
  logic [3:0] e_misc, k_misc;
  int num_errors = 0;
  int n_checks = 0;
  int slot_pin [NS];
  logic [31:0] rng = 32'h000165CD;

  // Free-running system clock
  always #5 clk_in = ~clk_in;

  port_crossbar_decoder dut_u (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .pin_input_mode_bits_in(mdin),
    .pin_output_mode_bits_in(mdout), .pin_skip_bits_in(skip), .port_latch_in(latch),
    .resource_enable_reg_a_in(ra), .resource_enable_reg_b_in(rb),
    .serial_pin_order_swap_in(swp), .slave_select_mode_in(ssm),
    .ext_interrupt_pin_select_in(eisel), .match_value_port0_in(mv0),
    .match_mask_port0_in(mm0), .match_value_port1_in(mv1), .match_mask_port1_in(mm1),
    .uart_transmit_line_in(utx), .periph_out_in(pout), .periph_oe_in(poe), .pad_in(pad),
    .pad_out_out(pad_out), .pad_oe_out(pad_oe), .pad_pullup_out(pull), .port_read_out(rd),
    .pin_routed_out(routed), .periph_in_out(pin_in), .uart_receive_line_out(urx),
    .ext_int_out(eint), .port_mismatch_out(mism));

  pad_world pads_u (.clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe),
    .pad_pullup_in(pull), .ext_level_in(ext_lvl), .ext_drive_in(ext_en), .pad_level_out(pad));

  // Xorshift source for random settings
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Masked compare with error report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    n_checks++;
    if ((got & msk) !== (exp & msk)) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got & msk, exp & msk);
    end
  endtask

  // Reference allocation and pad behaviour from the current settings
  task automatic model();
    logic [NA-1:0] taken;
    logic [NS-1:0] want;
    logic xe, ur, v, od, den;
    int p;
    int s;
    xe = rb[RB_ROUTER_EN];
    ur = xe & ra[RA_UART];
    taken = skip;
    e_rt = 20'h00000;
    want = {rb[RB_T1], rb[RB_T0], rb[RB_ECI], rb[1:0] == PCA_THREE, rb[1], rb[1:0] != PCA_NONE,
      ra[RA_SYSCLK], ra[RA_CP0A], ra[RA_CP0], {2{ra[RA_SMB1]}}, {2{ra[RA_SMB0]}},
      ra[RA_SPI] & ssm, {3{ra[RA_SPI]}}};
    if (ur) begin
      taken = taken | UART_MASK;
      e_rt = UART_MASK;
    end
    for (s = 0; s < NS; s++) begin
      slot_pin[s] = -1;
      for (p = 0; p < NA; p++) begin
        if (xe && want[s] && slot_pin[s] < 0 && !taken[p]) begin
          slot_pin[s] = p;
          taken[p] = 1'b1;
          e_rt[p] = 1'b1;
        end
      end
    end
    for (s = 0; s < 2; s++) begin
      if (swp[s]) begin
        p = slot_pin[4 + 2 * s];
        slot_pin[4 + 2 * s] = slot_pin[5 + 2 * s];
        slot_pin[5 + 2 * s] = p;
      end
    end
    for (p = 0; p < NP; p++) begin
      v = latch[p];
      den = 1'b1;
      od = !mdout[p];
      if (ur && p == UART_TX_PIN) v = utx;
      if (ur && p == UART_RX_PIN) den = 1'b0;
      for (s = 0; s < NS; s++) begin
        if (slot_pin[s] == p) begin
          v = pout[s];
          den = poe[s];
          od = od | (s >= S_SDA0 && s <= S_SCL1);
        end
      end
      den = den & xe & mdin[p];
      e_oe[p] = den & (!od | !v);
      e_out[p] = !od & v;
      e_pu[p] = mdin[p] & !rb[RB_WPU_DIS] & od & !e_oe[p];
      e_pad[p] = e_oe[p] ? e_out[p] : (ext_en[p] ? ext_lvl[p] : 1'b1);
      e_kn[p] = e_oe[p] | ext_en[p] | e_pu[p] | !mdin[p];
    end
    e_rd = e_pad & mdin;
    for (s = 0; s < NS; s++) begin
      e_pin[s] = slot_pin[s] >= 0 ? e_rd[slot_pin[s]] : 1'b0;
      k_pin[s] = slot_pin[s] < 0 || e_kn[slot_pin[s]];
    end
    e_misc = {ur & e_rd[UART_RX_PIN], e_rd[eisel[6:4]], e_rd[eisel[2:0]],
      (|((e_rd[7:0] ^ mv0) & mm0 & mdin[7:0])) | (|((e_rd[15:8] ^ mv1) & mm1 & mdin[15:8]))};
    k_misc = {!ur | e_kn[UART_RX_PIN], e_kn[eisel[6:4]], e_kn[eisel[2:0]],
      (~e_kn[15:0] & {mm1, mm0}) == 16'h0000};
  endtask

  // Let settings and pads settle, then compare every output
  task automatic check();
    model();
    repeat (10) @(posedge clk_in);
    #2;
    cmp(32'(pad_oe), 32'(e_oe), 32'hFFFFFFFF);
    cmp(32'(pad_out), 32'(e_out), 32'(e_oe));
    cmp(32'(pull), 32'(e_pu), 32'hFFFFFFFF);
    cmp(32'(rd), 32'(e_rd), 32'(e_kn));
    cmp(32'(routed), 32'(e_rt), 32'hFFFFFFFF);
    cmp(32'(pin_in), 32'(e_pin), 32'(k_pin));
    cmp(32'({urx, eint, mism}), 32'(e_misc), 32'(k_misc));
  endtask

  // Configure in the advised order, router enable last
  task automatic apply(input logic [NP-1:0] mi, input logic [NP-1:0] mo,
    input logic [NA-1:0] sk, input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_in) #1 mdin = mi;
    @(posedge clk_in) #1 mdout = mo;
    @(posedge clk_in) #1 skip = sk;
    @(posedge clk_in) #1 ra = a;
    rb = b & 8'hBF;
    @(posedge clk_in) #1 rb = b;
    check();
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    logic [7:0] b;
    repeat (20) @(posedge clk_in);
    #1;
    cmp(32'(pad_oe | pull | rd), 32'h00000000, 32'hFFFFFFFF);
    arst_n_in = 1'b1;
    check();
    $display("Reset test done, errors %0d", num_errors);
    apply(IN_MODE_RST, 21'h000000, 20'h0000C, 8'h05, 8'h41);
    cmp(32'(routed), 32'h00000073, 32'hFFFFFFFF);
    $display("Priority example done, errors %0d", num_errors);
    // Alternating board levels so a swapped data/clock pair reads differently
    @(posedge clk_in) #1 ext_lvl = 21'h0AAAAA;
    for (int i = 0; i < 8; i++) begin
      ssm = i[2];
      swp = 2'(i);
      apply(IN_MODE_RST, 21'h0F0F0F, 20'h00001, 8'h47, 8'h40 | 8'(i & 3));
    end
    $display("Codes test done, errors %0d", num_errors);
    apply(IN_MODE_RST, 21'h1F0F0F, 20'hFFF80, 8'h7F, 8'h7B);
    apply(IN_MODE_RST, 21'h1F0F0F, 20'h00000, 8'h7F, 8'h3F);
    $display("Exhaust and disable done, errors %0d", num_errors);
    for (int i = 0; i < 150; i++) begin
      @(posedge clk_in) #1 latch = NP'(rnd());
      ext_lvl = NP'(rnd());
      ext_en = NP'(rnd() | rnd());
      pout = NS'(rnd());
      poe = NS'(rnd());
      {utx, ssm, swp, eisel} = 12'(rnd());
      {mv0, mm0, mv1, mm1} = rnd();
      b = 8'(rnd());
      b[6] = b[6] | b[0];
      apply(NP'(rnd() | rnd()), NP'(rnd()), NA'(rnd() & rnd()), 8'(rnd()), b);
    end
    $display("Random test done, errors %0d", num_errors);
    print_verdict();
  end
endmodule
